// File: logic/csie_map.vh
// Register map, field positions, reset values and bus codes of the comparator shortcut and interrupt block.
`ifndef CSIE_MAP_VH
`define CSIE_MAP_VH

// ==========================================================================
// Register byte offsets
`define CSIE_OFF_EVT_READY 12'h100
`define CSIE_OFF_EVT_DOWN 12'h104
`define CSIE_OFF_EVT_UP 12'h108
`define CSIE_OFF_EVT_CROSS 12'h10c
`define CSIE_OFF_SHORTCUTS 12'h200
`define CSIE_OFF_IRQ_DIRECT 12'h300
`define CSIE_OFF_IRQ_SET 12'h304
`define CSIE_OFF_IRQ_CLEAR 12'h308

// ==========================================================================
// Address width of the register window
`define CSIE_AW 12

// ==========================================================================
// Shortcut field positions
`define CSIE_SC_READY_SAMPLE 0
`define CSIE_SC_READY_STOP 1
`define CSIE_SC_DOWN_STOP 2
`define CSIE_SC_UP_STOP 3
`define CSIE_SC_CROSS_STOP 4
`define CSIE_SC_W 5

// ==========================================================================
// Event and interrupt enable field positions
`define CSIE_EV_READY 0
`define CSIE_EV_DOWN 1
`define CSIE_EV_UP 2
`define CSIE_EV_CROSS 3
`define CSIE_EV_W 4

// ==========================================================================
// Reset values
`define CSIE_RST_SHORTCUTS 5'h00
`define CSIE_RST_IRQ_EN 4'h0
`define CSIE_RST_EVT 4'h0

// ==========================================================================
// AXI4-Lite response codes
`define CSIE_RESP_OKAY 2'h0
`define CSIE_RESP_SLVERR 2'h2

`endif

// File: logic/csie_top.v
// Comparator event shortcuts, event flags and interrupt enables behind an AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none

`include "csie_map.vh"

module csie_top (
    // Clock, reset and clock enable
    input wire i_clk,
    input wire i_arst_n,
    input wire i_ce,
    // Comparator status from the analog side
    input wire i_cmp_ready,
    input wire i_cmp_down,
    input wire i_cmp_up,
    // Task triggers towards the analog side
    output reg o_task_sample,
    output reg o_task_stop,
    // Interrupt
    output reg o_irq,
    // AXI4-Lite write address channel
    input wire [`CSIE_AW-1:0] i_awaddr,
    input wire [2:0] i_awprot,
    input wire i_awvalid,
    output reg o_awready,
    // AXI4-Lite write data channel
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    input wire i_wvalid,
    output reg o_wready,
    // AXI4-Lite write response channel
    output reg [1:0] o_bresp,
    output reg o_bvalid,
    input wire i_bready,
    // AXI4-Lite read address channel
    input wire [`CSIE_AW-1:0] i_araddr,
    input wire [2:0] i_arprot,
    input wire i_arvalid,
    output reg o_arready,
    // AXI4-Lite read data channel
    output reg [31:0] o_rdata,
    output reg [1:0] o_rresp,
    output reg o_rvalid,
    input wire i_rready
);

    // ======================================================================
    // Address decode helper

    // Compares word addresses only, so the two low byte bits never matter.
    function csie_hit;
        input [`CSIE_AW-1:0] addr;
        input [`CSIE_AW-1:0] off;
        begin
            csie_hit = (addr[`CSIE_AW-1:2] == off[`CSIE_AW-1:2]);
        end
    endfunction

    // True when the address names any register of this block.
    function csie_mapped;
        input [`CSIE_AW-1:0] addr;
        begin
            csie_mapped = csie_hit(addr, `CSIE_OFF_EVT_READY) |
                          csie_hit(addr, `CSIE_OFF_EVT_DOWN) |
                          csie_hit(addr, `CSIE_OFF_EVT_UP) |
                          csie_hit(addr, `CSIE_OFF_EVT_CROSS) |
                          csie_hit(addr, `CSIE_OFF_SHORTCUTS) |
                          csie_hit(addr, `CSIE_OFF_IRQ_DIRECT) |
                          csie_hit(addr, `CSIE_OFF_IRQ_SET) |
                          csie_hit(addr, `CSIE_OFF_IRQ_CLEAR);
        end
    endfunction

    // ======================================================================
    // Declarations

    reg [2:0] sync1_r;
    reg [2:0] sync2_r;
    reg [2:0] sync3_r;
    wire ev_ready;
    wire ev_down;
    wire ev_up;
    wire ev_cross;
    wire [`CSIE_EV_W-1:0] ev_vec;

    reg [`CSIE_SC_W-1:0] shortcuts_r;
    reg [`CSIE_SC_W-1:0] shortcuts_nxt;
    reg [`CSIE_EV_W-1:0] irq_en_r;
    reg [`CSIE_EV_W-1:0] irq_en_nxt;
    reg [`CSIE_EV_W-1:0] evt_r;
    reg [`CSIE_EV_W-1:0] evt_nxt;

    reg [`CSIE_AW-1:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg aw_held_r;
    reg w_held_r;
    wire aw_take;
    wire w_take;
    wire do_wr;
    wire wr_lane0;
    wire ar_take;
    reg [31:0] rdata_nxt;

    wire task_sample_nxt;
    wire task_stop_nxt;

    // ======================================================================
    // Comparator input synchronisers

    // The analog status lines are asynchronous, so each passes two flops
    // before anything looks at it; the third flop only feeds edge detection.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            sync3_r <= 3'h0;
        end else if (i_ce) begin
            sync1_r <= {i_cmp_up, i_cmp_down, i_cmp_ready};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // ======================================================================
    // Event generation

    // Ready fires on the rising edge of the valid-output indication.
    assign ev_ready = sync2_r[0] & ~sync3_r[0];
    assign ev_down = sync2_r[1] & ~sync3_r[1];
    assign ev_up = sync2_r[2] & ~sync3_r[2];
    // Any crossing fires in the same cycle as its directional event.
    assign ev_cross = ev_down | ev_up;
    assign ev_vec = {ev_cross, ev_up, ev_down, ev_ready};

    // ======================================================================
    // Shortcut routing from events to tasks

    // Tasks are pulses of one cycle, one cycle after the event.
    assign task_sample_nxt = ev_ready & shortcuts_r[`CSIE_SC_READY_SAMPLE];
    assign task_stop_nxt = (ev_ready & shortcuts_r[`CSIE_SC_READY_STOP]) |
                           (ev_down & shortcuts_r[`CSIE_SC_DOWN_STOP]) |
                           (ev_up & shortcuts_r[`CSIE_SC_UP_STOP]) |
                           (ev_cross & shortcuts_r[`CSIE_SC_CROSS_STOP]);

    // Task and interrupt outputs are registered so no decode glitch leaves.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_task_sample <= 1'b0;
            o_task_stop <= 1'b0;
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_task_sample <= task_sample_nxt;
            o_task_stop <= task_stop_nxt;
            o_irq <= |(evt_r & irq_en_r);
        end
    end

    // ======================================================================
    // Write channel capture

    // Address and data are accepted in either order and held until the
    // write is carried out; each ready drops while its channel is held.
    assign aw_take = i_awvalid & o_awready;
    assign w_take = i_wvalid & o_wready;
    assign do_wr = aw_held_r & w_held_r & ~o_bvalid;
    // Every field lives in byte lane zero, so only that strobe matters.
    assign wr_lane0 = do_wr & wstrb_r[0];

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            awaddr_r <= {`CSIE_AW{1'b0}};
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= `CSIE_RESP_OKAY;
        end else if (i_ce) begin
            if (aw_take) begin
                awaddr_r <= i_awaddr;
                aw_held_r <= 1'b1;
            end else if (do_wr) begin
                aw_held_r <= 1'b0;
            end
            if (w_take) begin
                wdata_r <= i_wdata;
                wstrb_r <= i_wstrb;
                w_held_r <= 1'b1;
            end else if (do_wr) begin
                w_held_r <= 1'b0;
            end
            o_awready <= ~(aw_held_r | aw_take) | do_wr;
            o_wready <= ~(w_held_r | w_take) | do_wr;
            if (do_wr) begin
                o_bvalid <= 1'b1;
                o_bresp <= csie_mapped(awaddr_r) ? `CSIE_RESP_OKAY : `CSIE_RESP_SLVERR;
            end else if (o_bvalid & i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Read channel

    // One read at a time: arready stays low from the address handshake
    // until the data handshake, which keeps the side effects to one read.
    assign ar_take = i_arvalid & o_arready;

    always @* begin
        rdata_nxt = 32'h00000000;
        if (csie_hit(i_araddr, `CSIE_OFF_EVT_READY)) begin
            rdata_nxt[0] = evt_r[`CSIE_EV_READY];
        end else if (csie_hit(i_araddr, `CSIE_OFF_EVT_DOWN)) begin
            rdata_nxt[0] = evt_r[`CSIE_EV_DOWN];
        end else if (csie_hit(i_araddr, `CSIE_OFF_EVT_UP)) begin
            rdata_nxt[0] = evt_r[`CSIE_EV_UP];
        end else if (csie_hit(i_araddr, `CSIE_OFF_EVT_CROSS)) begin
            rdata_nxt[0] = evt_r[`CSIE_EV_CROSS];
        end else if (csie_hit(i_araddr, `CSIE_OFF_SHORTCUTS)) begin
            rdata_nxt[`CSIE_SC_W-1:0] = shortcuts_r;
        end else if (csie_hit(i_araddr, `CSIE_OFF_IRQ_DIRECT) |
                     csie_hit(i_araddr, `CSIE_OFF_IRQ_SET) |
                     csie_hit(i_araddr, `CSIE_OFF_IRQ_CLEAR)) begin
            rdata_nxt[`CSIE_EV_W-1:0] = irq_en_r;
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h00000000;
            o_rresp <= `CSIE_RESP_OKAY;
        end else if (i_ce) begin
            if (ar_take) begin
                o_arready <= 1'b0;
                o_rvalid <= 1'b1;
                o_rdata <= rdata_nxt;
                o_rresp <= csie_mapped(i_araddr) ? `CSIE_RESP_OKAY : `CSIE_RESP_SLVERR;
            end else if (o_rvalid & i_rready) begin
                o_rvalid <= 1'b0;
                o_arready <= 1'b1;
            end else if (~o_rvalid) begin
                o_arready <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Shortcut register

    always @* begin
        shortcuts_nxt = shortcuts_r;
        if (wr_lane0 & csie_hit(awaddr_r, `CSIE_OFF_SHORTCUTS)) begin
            shortcuts_nxt = wdata_r[`CSIE_SC_W-1:0];
        end
    end

    // ======================================================================
    // Interrupt enables

    // All three views act on the same flops, so software running in two
    // contexts can set and clear single bits without a read-modify-write.
    always @* begin
        irq_en_nxt = irq_en_r;
        if (wr_lane0 & csie_hit(awaddr_r, `CSIE_OFF_IRQ_DIRECT)) begin
            irq_en_nxt = wdata_r[`CSIE_EV_W-1:0];
        end else if (wr_lane0 & csie_hit(awaddr_r, `CSIE_OFF_IRQ_SET)) begin
            irq_en_nxt = irq_en_r | wdata_r[`CSIE_EV_W-1:0];
        end else if (wr_lane0 & csie_hit(awaddr_r, `CSIE_OFF_IRQ_CLEAR)) begin
            irq_en_nxt = irq_en_r & ~wdata_r[`CSIE_EV_W-1:0];
        end
    end

    // ======================================================================
    // Event flags

    // A flag is sticky: a read of its register clears it, and a write
    // stores bit zero. A new event in the same cycle always wins, so no
    // event is lost to a clear that races it.
    always @* begin
        evt_nxt = evt_r;
        if (wr_lane0 & csie_hit(awaddr_r, `CSIE_OFF_EVT_READY)) begin
            evt_nxt[`CSIE_EV_READY] = wdata_r[0];
        end
        if (wr_lane0 & csie_hit(awaddr_r, `CSIE_OFF_EVT_DOWN)) begin
            evt_nxt[`CSIE_EV_DOWN] = wdata_r[0];
        end
        if (wr_lane0 & csie_hit(awaddr_r, `CSIE_OFF_EVT_UP)) begin
            evt_nxt[`CSIE_EV_UP] = wdata_r[0];
        end
        if (wr_lane0 & csie_hit(awaddr_r, `CSIE_OFF_EVT_CROSS)) begin
            evt_nxt[`CSIE_EV_CROSS] = wdata_r[0];
        end
        if (ar_take & csie_hit(i_araddr, `CSIE_OFF_EVT_READY)) begin
            evt_nxt[`CSIE_EV_READY] = 1'b0;
        end
        if (ar_take & csie_hit(i_araddr, `CSIE_OFF_EVT_DOWN)) begin
            evt_nxt[`CSIE_EV_DOWN] = 1'b0;
        end
        if (ar_take & csie_hit(i_araddr, `CSIE_OFF_EVT_UP)) begin
            evt_nxt[`CSIE_EV_UP] = 1'b0;
        end
        if (ar_take & csie_hit(i_araddr, `CSIE_OFF_EVT_CROSS)) begin
            evt_nxt[`CSIE_EV_CROSS] = 1'b0;
        end
        evt_nxt = evt_nxt | ev_vec;
    end

    // ======================================================================
    // Control state

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            shortcuts_r <= `CSIE_RST_SHORTCUTS;
            irq_en_r <= `CSIE_RST_IRQ_EN;
            evt_r <= `CSIE_RST_EVT;
        end else if (i_ce) begin
            shortcuts_r <= shortcuts_nxt;
            irq_en_r <= irq_en_nxt;
            evt_r <= evt_nxt;
        end
    end

    // The protection bits carry no meaning for this block.
    wire unused_prot;
    assign unused_prot = ^{i_awprot, i_arprot, wstrb_r[3:1], wdata_r[31:`CSIE_SC_W]};

endmodule

`default_nettype wire

// File: testbench/csie_assertions.sv
// Port-level checker for the comparator shortcut and interrupt block.
`timescale 1ns/1ps
`default_nettype none
module csie_chk (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Comparator pins and task triggers
    input wire logic i_cmp_ready,
    input wire logic i_cmp_down,
    input wire logic i_cmp_up,
    input wire logic o_task_sample,
    input wire logic o_task_stop,
    // Register bus handshakes
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic [1:0] o_bresp,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic i_rready
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    // Any pin that can cause a stop trigger.
    wire logic any_pin;
    assign any_pin = i_cmp_ready | i_cmp_down | i_cmp_up;

    // =====================================================================
    // Task triggers: a pulse follows its pin three edges later.
    sample_pulse_a: assert property (o_task_sample |=> !o_task_sample)
        else $error("sample trigger wider than one cycle");
    sample_cause_a: assert property (o_task_sample |-> $past(i_cmp_ready, 3))
        else $error("sample trigger without ready pin");
    stop_cause_a: assert property (o_task_stop |-> $past(any_pin, 3))
        else $error("stop trigger without comparator pin");

    // =====================================================================
    // Register bus timing as promised in the hand-over.
    wr_answer_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> !o_bvalid ##1 o_bvalid)
        else $error("write response not two cycles after take");
    aw_refuse_a: assert property (i_awvalid && o_awready |=> !o_awready)
        else $error("write address accepted twice");
    rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
        else $error("read data not one cycle after take");
    b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped while stalled");
    r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped while stalled");
    b_drop_a: assert property (o_bvalid && i_bready |=> !o_bvalid)
        else $error("write response repeated");

    // Main scenarios reached.
    cover property (o_task_sample);
    cover property (o_task_stop);
    cover property (o_rvalid && !i_rready);
endmodule

bind csie_top csie_chk chk (.i_clk, .i_arst_n, .i_cmp_ready, .i_cmp_down, .i_cmp_up, .o_task_sample,
    .o_task_stop, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_arvalid, .o_arready, .o_rdata, .o_rvalid, .i_rready);
`default_nettype wire

// File: testbench/csie_top_bench.sv
// Self-checking bench for the comparator shortcut and interrupt block.
`timescale 1ns/1ps
`default_nettype none
`include "csie_map.vh"
module csie_top_bench;
    // =====================================================================
    // Stimulus and observed signals
    logic i_clk = 0, i_arst_n = 0, i_cmp_ready = 0, i_cmp_down = 0, i_cmp_up = 0;
    logic [11:0] i_awaddr = 0, i_araddr = 0;
    logic [31:0] i_wdata = 0;
    logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
    logic i_ce = 1;
    logic [3:0] i_wstrb = 4'hf;
    wire logic o_task_sample, o_task_stop, o_irq, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    wire logic [1:0] o_bresp, o_rresp;
    wire logic [31:0] o_rdata;
    int err_total = 0, total_checks = 0, n_smp = 0, n_stp = 0;

    // Protection is not decoded, so it stays fixed.
    csie_top dut (.i_clk, .i_arst_n, .i_ce, .i_cmp_ready, .i_cmp_down, .i_cmp_up, .o_task_sample,
        .o_task_stop, .o_irq, .i_awaddr, .i_awprot(3'h0), .i_awvalid, .o_awready, .i_wdata,
        .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
        .i_arprot(3'h0), .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready);

    // Clock at 125 MHz.
    initial forever #4 i_clk = ~i_clk;

    // Count trigger pulses so each event can be judged by count.
    always @(posedge i_clk) begin
        n_smp <= n_smp + int'(o_task_sample === 1'h1);
        n_stp <= n_stp + int'(o_task_stop === 1'h1);
    end

    // =====================================================================
    // Comparison and closing
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        if (err_total == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // =====================================================================
    // Bus master; st holds the response ready low for that many cycles.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rs = 2'h0, input int st = 0);
        int n = 0;
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1;
        i_wvalid <= 1;
        while (1) begin
            @(posedge i_clk);
            if (o_bvalid && i_bready) break;
            if (o_awready) i_awvalid <= 0;
            if (o_wready) i_wvalid <= 0;
            n++;
            if (n > st) i_bready <= 1;
        end
        i_bready <= 0;
        chk(o_bresp, rs);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] rs = 2'h0, input int st = 0);
        int n = 0;
        i_araddr <= a;
        i_arvalid <= 1;
        while (1) begin
            @(posedge i_clk);
            if (o_rvalid && i_rready) break;
            if (o_arready) i_arvalid <= 0;
            n++;
            if (n > st) i_rready <= 1;
        end
        i_rready <= 0;
        chk(o_rdata, exp);
        chk(o_rresp, rs);
    endtask

    // Pulse one comparator pin; the trigger lands three edges after it.
    task automatic fire(input int p, input int es, input int et);
        int s0, t0;
        s0 = n_smp;
        t0 = n_stp;
        case (p)
            0: i_cmp_ready <= 1;
            1: i_cmp_down <= 1;
            default: i_cmp_up <= 1;
        endcase
        repeat (3) @(posedge i_clk);
        {i_cmp_ready, i_cmp_down, i_cmp_up} <= 3'h0;
        repeat (6) @(posedge i_clk);
        chk(n_smp - s0, es);
        chk(n_stp - t0, et);
    endtask

    // =====================================================================
    // Main sequence.
    initial begin
        repeat (10) @(posedge i_clk);
        i_arst_n <= 1;
        repeat (2) @(posedge i_clk);
        rd(`CSIE_OFF_SHORTCUTS, 32'h0);
        rd(`CSIE_OFF_IRQ_DIRECT, 32'h0);
        wr(`CSIE_OFF_SHORTCUTS, 32'hffffffff);
        rd(`CSIE_OFF_SHORTCUTS, 32'h1f, 2'h0, 2);
        wr(`CSIE_OFF_IRQ_DIRECT, 32'h5);
        rd(`CSIE_OFF_IRQ_SET, 32'h5);
        wr(`CSIE_OFF_IRQ_SET, 32'ha, 2'h0, 2);
        rd(`CSIE_OFF_IRQ_DIRECT, 32'hf);
        wr(`CSIE_OFF_IRQ_SET, 32'h0);
        wr(`CSIE_OFF_IRQ_CLEAR, 32'h3);
        rd(`CSIE_OFF_IRQ_CLEAR, 32'hc);
        wr(`CSIE_OFF_IRQ_CLEAR, 32'h0);
        rd(`CSIE_OFF_IRQ_DIRECT, 32'hc);
        wr(`CSIE_OFF_IRQ_DIRECT, 32'h1);
        rd(`CSIE_OFF_IRQ_DIRECT, 32'h1);
        wr(`CSIE_OFF_IRQ_CLEAR, 32'h1);
        rd(`CSIE_OFF_IRQ_SET, 32'h0);
        // Unmapped place: refused on both channels.
        wr(12'h010, 32'h1, 2'h2);
        rd(12'h010, 32'h0, 2'h2);
        // Each shortcut alone, then none, against every pin.
        for (int b = 0; b < 6; b++) begin
            wr(`CSIE_OFF_SHORTCUTS, b < 5 ? 32'h1 << b : 32'h0);
            for (int p = 0; p < 3; p++) begin
                fire(p, b == 0 && p == 0, (b == 1 && p == 0) || (b == p + 1 && p > 0) || (b == 4 && p > 0));
            end
        end
        // Every flag was raised; a read returns it and clears it.
        for (int i = 0; i < 4; i++) rd(12'h100 + 12'(4 * i), 32'h1);
        rd(`CSIE_OFF_EVT_CROSS, 32'h0);
        // Masked flag stays quiet until its enable is set.
        fire(1, 0, 0);
        chk(o_irq, 1'h0);
        wr(`CSIE_OFF_IRQ_SET, 32'h8);
        repeat (2) @(posedge i_clk);
        chk(o_irq, 1'h1);
        wr(`CSIE_OFF_IRQ_CLEAR, 32'h8);
        repeat (2) @(posedge i_clk);
        chk(o_irq, 1'h0);
        wr(`CSIE_OFF_IRQ_DIRECT, 32'h2);
        repeat (2) @(posedge i_clk);
        chk(o_irq, 1'h1);
        rd(`CSIE_OFF_EVT_UP, 32'h0);
        rd(`CSIE_OFF_EVT_DOWN, 32'h1);
        repeat (2) @(posedge i_clk);
        chk(o_irq, 1'h0);
        // Clock enable low freezes the synchronisers, so that pulse is missed.
        wr(`CSIE_OFF_SHORTCUTS, 32'h1);
        i_ce <= 0;
        fire(0, 0, 0);
        i_ce <= 1;
        fire(0, 1, 0);
        // A write without its low byte strobe leaves the register alone.
        i_wstrb <= 4'he;
        wr(`CSIE_OFF_SHORTCUTS, 32'h0);
        i_wstrb <= 4'hf;
        rd(`CSIE_OFF_SHORTCUTS, 32'h1);
        // A reset in mid-run returns shortcuts, enables and flags to zero.
        i_arst_n <= 0;
        repeat (2) @(posedge i_clk);
        i_arst_n <= 1;
        repeat (2) @(posedge i_clk);
        rd(`CSIE_OFF_SHORTCUTS, 32'h0);
        rd(`CSIE_OFF_IRQ_DIRECT, 32'h0);
        rd(`CSIE_OFF_EVT_CROSS, 32'h0);
        wrap_up;
    end

    // The sequence needs about 320 cycles; this cuts a hang short.
    initial begin
        #100000;
        err_total++;
        wrap_up;
    end
endmodule
`default_nettype wire
